// >>> dv/sensor_tx_model.sv
// Transmitter-side model: lane error, frame start and long header pulses.
// Assumes the bench calls its tasks; outputs change just after a rising link edge.
`timescale 1ns/1ps
module sensor_tx_model
  import csi2_rx_status_pkg::*;
(
  input  wire logic i_clk_link,
  output lane_err_t o_lane_err,
  output logic      o_frame_start,
  output logic      o_hdr_valid,
  output hdr_t      o_hdr
);
  // ************************************************************
  // Pulse drivers
  // ************************************************************
  initial begin
    o_lane_err    = ERR_RESET;
    o_frame_start = 1'b0;
    o_hdr_valid   = 1'b0;
    o_hdr         = HDR_RESET;
  end

  task automatic pulse_err(input lane_err_t e);
    @(posedge i_clk_link);
    o_lane_err <= e;
    @(posedge i_clk_link);
    o_lane_err <= ERR_RESET;
  endtask

  task automatic frame();
    @(posedge i_clk_link);
    o_frame_start <= 1'b1;
    @(posedge i_clk_link);
    o_frame_start <= 1'b0;
  endtask

  // Header lines are stale after the pulse, so they show the inverse, not the last value
  task automatic send_hdr(input hdr_t h);
    @(posedge i_clk_link);
    o_hdr_valid <= 1'b1;
    o_hdr       <= h;
    @(posedge i_clk_link);
    o_hdr_valid <= 1'b0;
    o_hdr       <= ~h;
    repeat (10) @(posedge i_clk_link);
  endtask
endmodule

// >>> dv/tb_csi2_rx_error_header_status.sv
// Bench for the lane error and header status registers, read over Avalon-MM.
// Assumes the transmitter model drives the link side; no partner-side faults.
`timescale 1ns/1ps
module tb_csi2_rx_error_header_status
  import csi2_rx_status_pkg::*;
;
  logic              i_clk_sys = 1'b0;
  logic              i_clk_link = 1'b0;
  logic              i_rst = 1'b1;
  lane_err_t         lane_err;
  logic              frame_start;
  logic              hdr_valid;
  hdr_t              hdr;
  logic [ADDR_W-1:0] i_avs_address = '0;
  logic              i_avs_read = 1'b0;
  logic              i_avs_write = 1'b0;
  logic [DATA_W-1:0] i_avs_writedata = '0;
  logic [DATA_W-1:0] o_avs_readdata;
  logic              o_avs_waitrequest;
  int                n_fail = 0;
  int                check_count = 0;
  logic [12:0]       acc;
  logic [31:0]       d;
  hdr_t              ha;
  hdr_t              hb;

  always #5 i_clk_sys = ~i_clk_sys;
  always #6 i_clk_link = ~i_clk_link;

  csi2_rx_error_header_status csi2_rx_error_header_status_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_clk_link(i_clk_link),
    .i_lane_err(lane_err), .i_frame_start(frame_start), .i_hdr_valid(hdr_valid),
    .i_hdr(hdr), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest));

  sensor_tx_model sensor_tx_model_i (
    .i_clk_link(i_clk_link), .o_lane_err(lane_err), .o_frame_start(frame_start),
    .o_hdr_valid(hdr_valid), .o_hdr(hdr));

  // ************************************************************
  // Bus and compare tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] idx, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_avs_address   <= {idx, 2'b00};
    i_avs_write     <= we;
    i_avs_read      <= ~we;
    i_avs_writedata <= 32'hFFFFFFFF;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    rd = o_avs_readdata;
    if (n >= 50) n_fail++;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  task automatic chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, r);
    check(r, {24'h000000, exp});
  endtask

  task automatic all_zero();
    for (int k = 8'h5E; k <= 8'h65; k++) chk(k[7:0], 8'h00);
  endtask

  task automatic final_report();
    $display("counts: checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    #300000;
    n_fail++;
    final_report();
  end

  initial begin
    ha = '{vc: 2'h2, dt: 6'h2B, wc: 16'h0A05, ecc: 6'h15};
    hb = '{vc: 2'h1, dt: 6'h1E, wc: 16'h0500, ecc: 6'h2A};
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    all_zero();
    $display("test reset values done");
    acc = 13'h0000;
    for (int b = 12; b >= 0; b--) begin
      sensor_tx_model_i.pulse_err(lane_err_t'(13'h0001 << b));
      acc = acc | (13'h0001 << b);
      repeat (10) @(posedge i_clk_sys);
      chk(IDX_LANE23, {acc[12:10], 1'b0, acc[9:7], 1'b0});
      chk(IDX_LANE01, {acc[6:4], 1'b0, acc[3:1], 1'b0});
      chk(IDX_CLK_LANE, {6'h00, acc[0], 1'b0});
    end
    $display("test lane flags done");
    sensor_tx_model_i.frame();
    sensor_tx_model_i.send_hdr(ha);
    repeat (10) @(posedge i_clk_sys);
    chk(IDX_HDR_ID, {ha.vc, ha.dt});
    chk(IDX_HDR_WC_LOW, ha.wc[7:0]);
    chk(IDX_HDR_WC_HIGH, ha.wc[15:8]);
    chk(IDX_HDR_ECC, {2'b00, ha.ecc});
    sensor_tx_model_i.send_hdr(hb);
    repeat (10) @(posedge i_clk_sys);
    chk(IDX_HDR_ID, {hb.vc, hb.dt});
    chk(IDX_HDR_WC_LOW, hb.wc[7:0]);
    chk(IDX_HDR_WC_HIGH, hb.wc[15:8]);
    chk(IDX_HDR_ECC, {2'b10, hb.ecc});
    bus(1'b1, IDX_HDR_ECC, d);
    chk(IDX_HDR_ECC, {2'b10, hb.ecc});
    $display("test header capture done");
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    all_zero();
    $display("test second reset done");
    final_report();
  end
endmodule

// >>> verilog/csi2_rx_error_header_status.sv
// Sticky lane error flags and capture of the last long packet header not dropped by the handshake, read over Avalon-MM.
// Assumes lane receivers and header decoder run on i_clk_link and give one-cycle pulses.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
// Function
// - Lane 3 correctable sync error sets bit 7 of lane 2/3 register.
// - Lane 3 uncorrectable sync error sets bit 6 of lane 2/3 register.
// - Lane 3 high-speed request control error sets bit 5.
// - Lane 2 correctable sync error sets bit 3 of lane 2/3 register.
// - Lane 2 uncorrectable sync error sets bit 2; bit 4 and 0 read zero.
// - Lane 2 high-speed request control error sets bit 1.
// - Clock lane control error sets bit 1 of clock lane register; rest zero.
// - Header virtual channel shows in bits 7:6 of identity register, reset zero.
// - Header data type shows in bits 5:0 of identity register.
// - Word count low byte is a read-only register resetting to zero.
// - Word count high byte is a separate read-only register.
// - Line length change inside a frame sets bit 7 of ECC register.
// - Header ECC shows in bits 5:0 of ECC register.
// - Lanes 1 and 0 carry the same three flags in a companion register.
module csi2_rx_error_header_status
  import csi2_rx_status_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  input  wire logic              i_clk_link,
  input  wire lane_err_t         i_lane_err,
  input  wire logic              i_frame_start,
  input  wire logic              i_hdr_valid,
  input  wire hdr_t              i_hdr,
  input  wire logic [ADDR_W-1:0] i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [DATA_W-1:0] i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic [DATA_W-1:0]      o_avs_readdata,
  output logic                   o_avs_waitrequest
);

  // ************************************************************
  // Helpers
  // ************************************************************
  // Packs two lanes into one register byte, reserved bits 4 and 0 stay zero
  function automatic logic [7:0] pair_byte(input lane_flags_t hi, input lane_flags_t lo);
    pair_byte = {hi.single_bit, hi.multi_bit, hi.hs_ctl, 1'b0,
                 lo.single_bit, lo.multi_bit, lo.hs_ctl, 1'b0};
  endfunction

  // Register index to bus byte address, one 32-bit word per register
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

  // ************************************************************
  // Link domain: events to toggles, header hold, line length check
  // ************************************************************
  typedef enum logic [0:0] {
    FR_IDLE = 1'b0,
    FR_SEEN = 1'b1
  } frame_state_t;

  logic [ERR_W-1:0] err_tgl_q;
  logic             chg_tgl_q;
  hdr_t             hold_q;
  logic             req_q;
  // Acknowledge toggle, returned to the link side through two flops
  logic             ack_q;
  logic             ack_s1_q;
  logic             ack_s2_q;
  // Frame tracker state and its reference word count
  frame_state_t     fr_q;
  logic [15:0]      first_wc_q;
  logic             line_chg_ev;

  // Line change: a later header in the frame carries another word count
  assign line_chg_ev = i_hdr_valid && (fr_q == FR_SEEN) && (i_hdr.wc != first_wc_q);

  // Each event flips a toggle, so a one link-cycle pulse survives the crossing
  always_ff @(posedge i_clk_link or posedge i_rst) begin
    if (i_rst) begin
      err_tgl_q <= ERR_RESET;
      chg_tgl_q <= 1'b0;
    end else begin
      err_tgl_q <= err_tgl_q ^ i_lane_err;
      chg_tgl_q <= chg_tgl_q ^ line_chg_ev;
    end
  end

  // First header of a frame sets the reference word count
  // A header coincident with frame start is not taken as reference
  always_ff @(posedge i_clk_link or posedge i_rst) begin
    if (i_rst) begin
      fr_q       <= FR_IDLE;
      first_wc_q <= 16'h0000;
    end else begin
      case (fr_q)
        FR_IDLE: begin
          if (i_hdr_valid && !i_frame_start) begin
            fr_q       <= FR_SEEN;
            first_wc_q <= i_hdr.wc;
          end
        end
        FR_SEEN: begin
          if (i_frame_start) begin
            fr_q <= FR_IDLE;
          end
        end
        default: fr_q <= FR_IDLE;
      endcase
    end
  end

  // Hold stays frozen until the system side has returned the toggle;
  // headers arriving meanwhile are dropped, which trades freshness for coherence
  always_ff @(posedge i_clk_link or posedge i_rst) begin
    if (i_rst) begin
      hold_q   <= HDR_RESET;
      req_q    <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
      if (i_hdr_valid && (req_q == ack_s2_q)) begin
        hold_q <= i_hdr;
        req_q  <= ~req_q;
      end
    end
  end

  // ************************************************************
  // System domain: synchronisers, sticky flags, header capture
  // ************************************************************
  logic [ERR_W-1:0] err_s1_q;
  logic [ERR_W-1:0] err_s2_q;
  logic [ERR_W-1:0] err_s3_q;
  logic [ERR_W-1:0] err_pulse;
  lane_err_t        flags_q;
  logic [2:0]       chg_s_q;
  logic             line_chg_q;
  logic [2:0]       req_s_q;
  logic             hdr_take;
  hdr_t             hdr_q;

  assign err_pulse = err_s2_q ^ err_s3_q;
  assign hdr_take  = req_s_q[1] ^ req_s_q[2];

  // Three stages: two to settle, a third to find the toggle edge
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      err_s1_q <= ERR_RESET;
      err_s2_q <= ERR_RESET;
      err_s3_q <= ERR_RESET;
      chg_s_q  <= 3'h0;
      req_s_q  <= 3'h0;
    end else begin
      err_s1_q <= err_tgl_q;
      err_s2_q <= err_s1_q;
      err_s3_q <= err_s2_q;
      chg_s_q  <= {chg_s_q[1:0], chg_tgl_q};
      req_s_q  <= {req_s_q[1:0], req_q};
    end
  end

  // No clear path exists, so a flag only ever gains bits
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      flags_q    <= ERR_RESET;
      line_chg_q <= 1'b0;
    end else begin
      flags_q    <= flags_q | err_pulse;
      line_chg_q <= line_chg_q | (chg_s_q[1] ^ chg_s_q[2]);
    end
  end

  // Header word crosses as a bundle; it stays still while the request is pending
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hdr_q <= HDR_RESET;
      ack_q <= 1'b0;
    end else begin
      if (hdr_take) begin
        hdr_q <= hold_q;
        ack_q <= req_s_q[1];
      end
    end
  end

  // ************************************************************
  // Avalon-MM slave
  // ************************************************************
  logic [7:0] rd_byte;

  // Unmapped and reserved offsets read as zero
  always_comb begin
    rd_byte = RESET_BYTE;
    case (i_avs_address)
      byte_addr(IDX_LANE01):      rd_byte = pair_byte(flags_q.lane1, flags_q.lane0);
      byte_addr(IDX_LANE23):      rd_byte = pair_byte(flags_q.lane3, flags_q.lane2);
      byte_addr(IDX_CLK_LANE):    rd_byte = {6'h00, flags_q.clk_hs_ctl, 1'b0};
      byte_addr(IDX_HDR_ID):      rd_byte = {hdr_q.vc, hdr_q.dt};
      byte_addr(IDX_HDR_WC_LOW):  rd_byte = hdr_q.wc[7:0];
      byte_addr(IDX_HDR_WC_HIGH): rd_byte = hdr_q.wc[15:8];
      byte_addr(IDX_HDR_ECC):     rd_byte = {line_chg_q, 1'b0, hdr_q.ecc};
      default:                    rd_byte = RESET_BYTE;
    endcase
  end

  // All registers are read-only; writes complete and change nothing
  // One wait state per access keeps read data registered, at the cost of bandwidth
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= {DATA_W{1'b0}};
    end else begin
      o_avs_waitrequest <= 1'b1;
      if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
        o_avs_waitrequest <= 1'b0;
        if (i_avs_read) begin
          o_avs_readdata <= {READ_PAD, rd_byte};
        end
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  // A pulse out of the synchroniser must land in its flag one edge later

  a_lane3_single: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(err_pulse[ERR_W-1]) |=> flags_q.lane3.single_bit)
    else $error("lane 3 single-bit flag not set");

  a_lane3_multi: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $changed(err_s3_q[ERR_W-2]) |-> flags_q.lane3.multi_bit)
    else $error("lane 3 multi-bit flag not set");

  a_lane3_ctl_set: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    err_pulse[ERR_W-3] |=> flags_q.lane3.hs_ctl)
    else $error("lane 3 control flag not set");

  a_lane2_single_set: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    err_pulse[ERR_W-4] |=> flags_q.lane2.single_bit)
    else $error("lane 2 single-bit flag not set");

  a_lane2_multi_set: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    err_pulse[ERR_W-5] |=> flags_q.lane2.multi_bit)
    else $error("lane 2 multi-bit flag not set");

  a_lane2_ctl_set: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    err_pulse[ERR_W-6] |=> flags_q.lane2.hs_ctl)
    else $error("lane 2 control flag not set");

  a_lane01_set: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (|err_pulse[ERR_W-7:1]) |=>
    ({flags_q.lane1, flags_q.lane0} & $past(err_pulse[ERR_W-7:1])) == $past(err_pulse[ERR_W-7:1]))
    else $error("lane 1/0 flag not set");

  a_clk_flag_set: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    err_pulse[0] |=> flags_q.clk_hs_ctl)
    else $error("clock lane flag not set");

  a_flag_sticky: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ($past(flags_q) & ~flags_q) == '0)
    else $error("lane flag cleared");

  a_line_sticky: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    line_chg_q |=> line_chg_q)
    else $error("line change flag cleared");

  // ************************************************************
  // Assertions: register reads
  // ************************************************************
  // Read data loaded at the accepting edge must show the state of that edge

  a_lane3_ctl: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_avs_read && o_avs_waitrequest && i_avs_address == byte_addr(IDX_LANE23))
    |=> o_avs_readdata[LANE_HI_CTL] == $past(flags_q.lane3.hs_ctl))
    else $error("lane 3 control flag misplaced");

  a_lane2_single: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_avs_read && o_avs_waitrequest && i_avs_address == byte_addr(IDX_LANE23))
    |=> o_avs_readdata[LANE_LO_SINGLE] == $past(flags_q.lane2.single_bit))
    else $error("lane 2 single-bit flag misplaced");

  a_lane23_reserved: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_avs_read && o_avs_waitrequest && i_avs_address == byte_addr(IDX_LANE23))
    |=> !o_avs_readdata[4] && !o_avs_readdata[0] && o_avs_readdata[31:8] == READ_PAD)
    else $error("lane 2/3 reserved bits not zero");

  a_lane23_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_avs_read && o_avs_waitrequest && i_avs_address == byte_addr(IDX_LANE23))
    |=> o_avs_readdata[7:0] == {$past(flags_q.lane3), 1'b0, $past(flags_q.lane2), 1'b0})
    else $error("lane 2/3 register wrong");

  a_lane01_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_avs_read && o_avs_waitrequest && i_avs_address == byte_addr(IDX_LANE01))
    |=> o_avs_readdata[7:0] == {$past(flags_q.lane1), 1'b0, $past(flags_q.lane0), 1'b0})
    else $error("lane 1/0 register wrong");

  a_clk_lane_bits: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_avs_read && o_avs_waitrequest && i_avs_address == byte_addr(IDX_CLK_LANE))
    |=> o_avs_readdata[7:0] == {6'h00, $past(flags_q.clk_hs_ctl), 1'b0})
    else $error("clock lane register wrong");

  a_hdr_id_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_avs_read && o_avs_waitrequest && i_avs_address == byte_addr(IDX_HDR_ID))
    |=> o_avs_readdata[7:0] == {$past(hdr_q.vc), $past(hdr_q.dt)})
    else $error("header identity register wrong");

  a_wc_low_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_avs_read && o_avs_waitrequest && i_avs_address == byte_addr(IDX_HDR_WC_LOW))
    |=> o_avs_readdata[7:0] == $past(hdr_q.wc[7:0]))
    else $error("word count low byte wrong");

  a_wc_high_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_avs_read && o_avs_waitrequest && i_avs_address == byte_addr(IDX_HDR_WC_HIGH))
    |=> o_avs_readdata[7:0] == $past(hdr_q.wc[15:8]))
    else $error("word count high byte wrong");

  a_ecc_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_avs_read && o_avs_waitrequest && i_avs_address == byte_addr(IDX_HDR_ECC))
    |=> o_avs_readdata[7:0] == {$past(line_chg_q), 1'b0, $past(hdr_q.ecc)})
    else $error("header ECC register wrong");

  a_readdata_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata))
    else $error("read data moved without a read");

  a_bus_answer: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ((i_avs_read || i_avs_write) && o_avs_waitrequest) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not one cycle");

  // ************************************************************
  // Assertions: header transfer and line length
  // ************************************************************
  // The capture must move all fields at once and only on a handshake

  a_hdr_coherent: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !hdr_take |=> $stable(hdr_q))
    else $error("header fields moved without capture");

  a_hdr_capture: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    hdr_take |=> hdr_q == $past(hold_q) ##1 !hdr_take [*2])
    else $error("header capture wrong");

  a_hdr_hold: assert property (@(posedge i_clk_link) disable iff (i_rst)
    (i_hdr_valid && (req_q == ack_s2_q)) |=> hold_q == $past(i_hdr))
    else $error("header not held on the link side");

  a_line_change: assert property (@(posedge i_clk_link) disable iff (i_rst)
    line_chg_ev |=> chg_tgl_q != $past(chg_tgl_q))
    else $error("line change not signalled");

  a_frame_rearm: assert property (@(posedge i_clk_link) disable iff (i_rst)
    i_frame_start |=> fr_q == FR_IDLE)
    else $error("frame start did not clear the reference");

  // ************************************************************
  // Covers
  // ************************************************************
  c_lane_error: cover property (@(posedge i_clk_sys) disable iff (i_rst) |err_pulse);
  c_hdr_take: cover property (@(posedge i_clk_sys) disable iff (i_rst) hdr_take);
  c_line_chg: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(line_chg_q));
  c_read: cover property (@(posedge i_clk_sys) disable iff (i_rst) i_avs_read && !o_avs_waitrequest);
  c_hdr_drop: cover property (@(posedge i_clk_link) disable iff (i_rst) i_hdr_valid && req_q != ack_s2_q);

endmodule

// >>> verilog/csi2_rx_status_pkg.sv
// Constants and carrier types for the CSI-2 receive error and header status block.
// Assumes an Avalon-MM slave with 32-bit data: register index times four is the byte address.
package csi2_rx_status_pkg;

  // ************************************************************
  // Register indices and bus geometry
  // ************************************************************
  localparam int          ADDR_W          = 10;
  localparam int          DATA_W          = 32;
  localparam logic [7:0]  IDX_LANE01      = 8'h5E;
  localparam logic [7:0]  IDX_LANE23      = 8'h5F;
  localparam logic [7:0]  IDX_CLK_LANE    = 8'h60;
  localparam logic [7:0]  IDX_HDR_ID      = 8'h61;
  localparam logic [7:0]  IDX_HDR_WC_LOW  = 8'h62;
  localparam logic [7:0]  IDX_HDR_WC_HIGH = 8'h63;
  localparam logic [7:0]  IDX_HDR_ECC     = 8'h64;
  localparam logic [7:0]  RESET_BYTE      = 8'h00;
  localparam logic [23:0] READ_PAD        = 24'h000000;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int LANE_HI_SINGLE = 7;
  localparam int LANE_HI_MULTI  = 6;
  localparam int LANE_HI_CTL    = 5;
  localparam int LANE_LO_SINGLE = 3;
  localparam int LANE_LO_MULTI  = 2;
  localparam int LANE_LO_CTL    = 1;
  localparam int CLK_CTL_BIT    = 1;
  localparam int LINE_CHG_BIT   = 7;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic single_bit;
    logic multi_bit;
    logic hs_ctl;
  } lane_flags_t;

  typedef struct packed {
    lane_flags_t lane3;
    lane_flags_t lane2;
    lane_flags_t lane1;
    lane_flags_t lane0;
    logic        clk_hs_ctl;
  } lane_err_t;

  typedef struct packed {
    logic [1:0]  vc;
    logic [5:0]  dt;
    logic [15:0] wc;
    logic [5:0]  ecc;
  } hdr_t;

  localparam int        ERR_W     = $bits(lane_err_t);
  localparam lane_err_t ERR_RESET = '0;
  localparam hdr_t      HDR_RESET = '0;

endpackage
